// ### rtl/stc_defines.svh
// Register offsets, field positions, reset values and counts of the timer
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

`define STC_OFS_CTRL_A 8'h00
`define STC_OFS_CTRL_B 8'h04
`define STC_OFS_CNT_LO 8'h08
`define STC_OFS_CNT_HI 8'h0C
`define STC_OFS_CMPA_LO 8'h10
`define STC_OFS_CMPA_HI 8'h14
`define STC_OFS_CMPB_LO 8'h18
`define STC_OFS_CMPB_HI 8'h1C
`define STC_OFS_CAP_LO 8'h20
`define STC_OFS_CAP_HI 8'h24
`define STC_OFS_FLAGS 8'h28

`define STC_A_FORCE_A 3
`define STC_A_FORCE_B 2
`define STC_A_FORCE_MASK 8'h0C
`define STC_B_FILTER 7
`define STC_B_EDGE 6
`define STC_B_RSVD_MASK 8'h20
`define STC_F_CAP 5
`define STC_F_CMPA 4
`define STC_F_CMPB 3
`define STC_F_OVF 2

`define STC_RST_BYTE 8'h00
`define STC_RST_WORD 16'h0000
`define STC_MAX 16'hFFFF
`define STC_TOP8 16'h00FF
`define STC_TOP9 16'h01FF
`define STC_TOP10 16'h03FF
`define STC_FILT_N 4

`endif

// ### rtl/stc_pkg.sv
// Types shared by the timer modules
package stc_pkg;
  typedef logic [7:0] stc_byte_t;
  typedef logic [15:0] stc_word_t;
  typedef logic [31:0] stc_data_t;
  typedef enum {STC_NORMAL, STC_CTC, STC_FAST, STC_PC, STC_PFC, STC_RSVD} stc_class_t;
endpackage : stc_pkg

// ### rtl/stc_cap_if.sv
// Capture path signals between the timer core and its input filter
`timescale 1ns/1ps
interface stc_cap_if;
  logic pin;
  logic filter_en;
  logic edge_sel;
  logic enable;
  logic trig;
  modport core (output pin, output filter_en, output edge_sel, output enable, input trig);
  modport filt (input pin, input filter_en, input edge_sel, input enable, output trig);
endinterface : stc_cap_if

// ### rtl/stc_capture_filter.sv
// Capture input noise filter and edge detector
`timescale 1ns/1ps
`include "stc_defines.svh"
module stc_capture_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture path
  stc_cap_if.filt cap
);
  import stc_pkg::*;
  logic [`STC_FILT_N-1:0] hist_q;
  logic filt_q;
  logic prev_q;
  logic trig_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[`STC_FILT_N-2:0], cap.pin};
    end
  end

  // Pin idles low after reset; a high pin then gives one rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= 1'b0;
    end else if (!cap.filter_en) begin
      filt_q <= cap.pin;
    end else if ((&hist_q) || (~|hist_q)) begin
      filt_q <= hist_q[0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      prev_q <= filt_q;
      trig_q <= cap.enable && (cap.edge_sel ? (filt_q && !prev_q) : (!filt_q && prev_q));
    end
  end

  assign cap.trig = trig_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_filter_hold;
    cap.filter_en && (hist_q != '0) && (hist_q != '1) |=> $stable(filt_q);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter output moved on mixed samples");

  property p_edge_sel;
    cap.enable && (filt_q != prev_q) && (filt_q == cap.edge_sel) |=> trig_q;
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("selected capture edge not taken");
endmodule : stc_capture_filter

// ### rtl/stc_timer.sv
// Sixteen-bit timer/counter with APB register access
`timescale 1ns/1ps
`include "stc_defines.svh"
// Functional notes
// - Force strobes act only in non-PWM modes
// - Force applies compare output action immediately
// - Force sets no flag, never clears counter
// - Force bits are strobes, read zero
// - Mode 0 counts to 0xFFFF, flags MAX
// - Phase-correct: update at TOP, flag BOTTOM
// - Clear-on-match modes 4, 12: immediate, MAX
// - Fast PWM: update BOTTOM, flag at TOP
// - Phase-frequency modes 8, 9: BOTTOM both
// - Filter needs four equal samples
// - Edge select: zero falling, one rising
// - Capture copies counter and sets flag
// - Capture off when capture sets top
// - Clock select: stop, prescales, external edges
// - External pin clocks even as output
// - Counter bytes move atomically via temp
// - Counter write blocks next tick's matches
// - Compare registers matched continuously with counter
// - Compare writes load both bytes together
// - Non-PWM output: off, toggle, clear, set
// - Capture flag cleared by ack or one
module stc_timer (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire stc_pkg::stc_byte_t PADDR,
  input wire stc_pkg::stc_data_t PWDATA,
  output stc_pkg::stc_data_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Timer pins
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic EXTERNAL_COUNT_PIN,
  output logic WAVE_OUT_A,
  output logic WAVE_OE_A,
  output logic WAVE_OUT_B,
  output logic WAVE_OE_B,
  // Event flags
  input wire logic CAP_VECTOR_ACK,
  output logic CAPTURE_FLAG,
  output logic COMPARE_FLAG_A,
  output logic COMPARE_FLAG_B,
  output logic OVERFLOW_FLAG
);
  import stc_pkg::*;

  function automatic logic mapped(input stc_byte_t a);
    case (a)
      `STC_OFS_CTRL_A, `STC_OFS_CTRL_B, `STC_OFS_CNT_LO, `STC_OFS_CNT_HI,
      `STC_OFS_CMPA_LO, `STC_OFS_CMPA_HI, `STC_OFS_CMPB_LO, `STC_OFS_CMPB_HI,
      `STC_OFS_CAP_LO, `STC_OFS_CAP_HI, `STC_OFS_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic stc_class_t mode_class(input logic [3:0] m);
    case (m)
      4'h0: mode_class = STC_NORMAL;
      4'h4, 4'hC: mode_class = STC_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = STC_FAST;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_class = STC_PC;
      4'h8, 4'h9: mode_class = STC_PFC;
      default: mode_class = STC_RSVD;
    endcase
  endfunction : mode_class

  function automatic stc_word_t mode_top(input logic [3:0] m, input stc_word_t cmpa,
                                         input stc_word_t cap);
    case (m)
      4'h1, 4'h5: mode_top = `STC_TOP8;
      4'h2, 4'h6: mode_top = `STC_TOP9;
      4'h3, 4'h7: mode_top = `STC_TOP10;
      4'h4, 4'h9, 4'hB, 4'hF: mode_top = cmpa;
      4'h8, 4'hA, 4'hC, 4'hE: mode_top = cap;
      default: mode_top = `STC_MAX;
    endcase
  endfunction : mode_top

  stc_byte_t ctrl_a_q;
  stc_byte_t ctrl_b_q;
  stc_byte_t temp_q;
  stc_word_t cnt_q;
  stc_word_t cap_q;
  stc_word_t top_val;
  stc_data_t prdata_q;
  logic [9:0] pre_q;
  logic [3:0] mode;
  logic [2:0] cs;
  logic [7:0] wd;
  stc_byte_t rd_byte;
  stc_byte_t lo_hi;
  stc_class_t cls;
  logic dir_down_q, block_q, ext_q, cap_flag_q, ovf_flag_q;
  logic wr_en, rd_setup, wr_ctrl_a, wr_cnt, clr, lo_rd;
  logic tick, at_top, at_bot, ovf_set, upd, non_pwm, icr_top, cap_hit, cap_set;
  stc_word_t buf_w [2];
  stc_word_t act_w [2];
  logic flag_w [2];
  logic wave_w [2];
  logic match_w [2];
  logic frc_w [2];
  logic [1:0] com_w [2];

  stc_cap_if cap_if ();

  assign wd = PWDATA[7:0];
  assign wr_en = PSEL && PENABLE && PWRITE && mapped(PADDR);
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wr_ctrl_a = wr_en && (PADDR == `STC_OFS_CTRL_A);
  assign wr_cnt = wr_en && (PADDR == `STC_OFS_CNT_LO);
  assign clr = wr_en && (PADDR == `STC_OFS_FLAGS);
  assign mode = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
  assign cs = ctrl_b_q[2:0];
  assign cls = mode_class(mode);
  assign non_pwm = (cls == STC_NORMAL) || (cls == STC_CTC) || (cls == STC_RSVD);
  assign icr_top = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
  assign top_val = mode_top(mode, act_w[0], cap_q);
  assign at_top = (cnt_q == top_val);
  assign at_bot = (cnt_q == `STC_RST_WORD);

  // Zero wait states; read data is sampled in the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
  assign PRDATA = prdata_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_a_q <= `STC_RST_BYTE;
      ctrl_b_q <= `STC_RST_BYTE;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_q <= wd & ~`STC_A_FORCE_MASK;
      end
      if (wr_en && (PADDR == `STC_OFS_CTRL_B)) begin
        ctrl_b_q <= wd & ~`STC_B_RSVD_MASK;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    lo_hi = 8'h00;
    lo_rd = 1'b0;
    case (PADDR)
      `STC_OFS_CTRL_A: rd_byte = ctrl_a_q;
      `STC_OFS_CTRL_B: rd_byte = ctrl_b_q;
      `STC_OFS_CNT_LO: begin
        rd_byte = cnt_q[7:0];
        lo_hi = cnt_q[15:8];
        lo_rd = 1'b1;
      end
      `STC_OFS_CMPA_LO: begin
        rd_byte = buf_w[0][7:0];
        lo_hi = buf_w[0][15:8];
        lo_rd = 1'b1;
      end
      `STC_OFS_CMPB_LO: begin
        rd_byte = buf_w[1][7:0];
        lo_hi = buf_w[1][15:8];
        lo_rd = 1'b1;
      end
      `STC_OFS_CAP_LO: begin
        rd_byte = cap_q[7:0];
        lo_hi = cap_q[15:8];
        lo_rd = 1'b1;
      end
      `STC_OFS_CNT_HI, `STC_OFS_CMPA_HI, `STC_OFS_CMPB_HI, `STC_OFS_CAP_HI: rd_byte = temp_q;
      `STC_OFS_FLAGS: begin
        rd_byte[`STC_F_CAP] = cap_flag_q;
        rd_byte[`STC_F_CMPA] = flag_w[0];
        rd_byte[`STC_F_CMPB] = flag_w[1];
        rd_byte[`STC_F_OVF] = ovf_flag_q;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // One shared temp byte; high byte latched with the low read, so no tearing
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      temp_q <= `STC_RST_BYTE;
    end else if (wr_en && ((PADDR == `STC_OFS_CNT_HI) || (PADDR == `STC_OFS_CMPA_HI) ||
                           (PADDR == `STC_OFS_CMPB_HI) || (PADDR == `STC_OFS_CAP_HI))) begin
      temp_q <= wd;
    end else if (rd_setup && lo_rd) begin
      temp_q <= lo_hi;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pre_q <= 10'h000;
      ext_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 10'h001;
      ext_q <= EXTERNAL_COUNT_PIN;
    end
  end

  // Pin direction is not looked at, so software can clock the counter
  always_comb begin
    case (cs)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = &pre_q[2:0];
      3'h3: tick = &pre_q[5:0];
      3'h4: tick = &pre_q[7:0];
      3'h5: tick = &pre_q[9:0];
      3'h6: tick = ext_q && !EXTERNAL_COUNT_PIN;
      3'h7: tick = !ext_q && EXTERNAL_COUNT_PIN;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_q <= `STC_RST_WORD;
      dir_down_q <= 1'b0;
    end else if (wr_cnt) begin
      cnt_q <= {temp_q, wd};
    end else if (tick) begin
      case (cls)
        STC_NORMAL, STC_CTC, STC_FAST: begin
          dir_down_q <= 1'b0;
          cnt_q <= at_top ? `STC_RST_WORD : cnt_q + 16'h0001;
        end
        STC_PC, STC_PFC: begin
          if (dir_down_q && at_bot) begin
            dir_down_q <= 1'b0;
            cnt_q <= cnt_q + 16'h0001;
          end else if (!dir_down_q && at_top) begin
            dir_down_q <= 1'b1;
            cnt_q <= cnt_q - 16'h0001;
          end else if (dir_down_q) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    ovf_set = 1'b0;
    upd = 1'b0;
    case (cls)
      STC_NORMAL, STC_CTC: ovf_set = tick && (cnt_q == `STC_MAX);
      STC_FAST: begin
        ovf_set = tick && at_top;
        upd = tick && at_top;
      end
      STC_PC: begin
        ovf_set = tick && at_bot && dir_down_q;
        upd = tick && at_top && !dir_down_q;
      end
      STC_PFC: begin
        ovf_set = tick && at_bot && dir_down_q;
        upd = tick && at_bot && dir_down_q;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    localparam stc_byte_t LO = (ch == 0) ? `STC_OFS_CMPA_LO : `STC_OFS_CMPB_LO;
    localparam int FRC_BIT = (ch == 0) ? `STC_A_FORCE_A : `STC_A_FORCE_B;
    localparam int FLAG_BIT = (ch == 0) ? `STC_F_CMPA : `STC_F_CMPB;
    logic [1:0] com, com_act;
    logic frc, match, special, flag_q, wave_q, wave_d;
    stc_word_t buf_q, act_q;

    assign com = (ch == 0) ? ctrl_a_q[7:6] : ctrl_a_q[5:4];
    assign frc = wr_ctrl_a && PWDATA[FRC_BIT] && non_pwm;
    // Force takes the output mode written alongside it
    assign com_act = frc ? ((ch == 0) ? PWDATA[7:6] : PWDATA[5:4]) : com;
    assign match = tick && !block_q && (cnt_q == act_q);
    assign special = (ch == 0) && (com == 2'b01) &&
                     ((cls == STC_FAST) ? (mode == 4'hF) : ((mode == 4'h9) || (mode == 4'hE)));

    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        buf_q <= `STC_RST_WORD;
      end else if (wr_en && (PADDR == LO)) begin
        buf_q <= {temp_q, wd};
      end
    end

    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        act_q <= `STC_RST_WORD;
      end else if (wr_en && (PADDR == LO) && non_pwm) begin
        act_q <= {temp_q, wd};
      end else if (non_pwm || upd) begin
        act_q <= buf_q;
      end
    end

    // Force never reaches the flag: only a real match sets it
    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        flag_q <= 1'b0;
      end else if (match) begin
        flag_q <= 1'b1;
      end else if (clr && wd[FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end

    always_comb begin
      wave_d = wave_q;
      case (cls)
        STC_NORMAL, STC_CTC, STC_RSVD: begin
          if (match || frc) begin
            case (com_act)
              2'b01: wave_d = !wave_q;
              2'b10: wave_d = 1'b0;
              2'b11: wave_d = 1'b1;
              default: ;
            endcase
          end
        end
        STC_FAST: begin
          if (match && com[1]) begin
            wave_d = com[0];
          end else if (match && special) begin
            wave_d = !wave_q;
          end
          if (tick && at_top && com[1]) begin
            wave_d = !com[0];
          end
        end
        STC_PC, STC_PFC: begin
          if (match && com[1]) begin
            wave_d = com[0] ^ dir_down_q;
          end else if (match && special) begin
            wave_d = !wave_q;
          end
        end
        default: ;
      endcase
    end

    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        wave_q <= 1'b0;
      end else begin
        wave_q <= wave_d;
      end
    end

    assign buf_w[ch] = buf_q;
    assign act_w[ch] = act_q;
    assign flag_w[ch] = flag_q;
    assign wave_w[ch] = wave_q;
    assign match_w[ch] = match;
    assign frc_w[ch] = frc;
    assign com_w[ch] = com;
  end

  assign cap_if.pin = CAPTURE_INPUT_PIN;
  assign cap_if.filter_en = ctrl_b_q[`STC_B_FILTER];
  assign cap_if.edge_sel = ctrl_b_q[`STC_B_EDGE];
  assign cap_if.enable = !icr_top;

  stc_capture_filter u_filter (
    .clk(CLK),
    .rst(SYS_RST),
    .cap(cap_if.filt)
  );

  // Gated again here: a trigger already in flight dies when the mode changes
  assign cap_hit = cap_if.trig && !icr_top;
  assign cap_set = cap_hit || (icr_top && tick && at_top);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cap_q <= `STC_RST_WORD;
    end else if (cap_hit) begin
      cap_q <= cnt_q;
    end else if (wr_en && (PADDR == `STC_OFS_CAP_LO)) begin
      cap_q <= {temp_q, wd};
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cap_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end else begin
      if (cap_set) begin
        cap_flag_q <= 1'b1;
      end else if ((clr && wd[`STC_F_CAP]) || CAP_VECTOR_ACK) begin
        cap_flag_q <= 1'b0;
      end
      if (ovf_set) begin
        ovf_flag_q <= 1'b1;
      end else if (clr && wd[`STC_F_OVF]) begin
        ovf_flag_q <= 1'b0;
      end
    end
  end

  assign WAVE_OUT_A = wave_w[0];
  assign WAVE_OUT_B = wave_w[1];
  assign WAVE_OE_A = |com_w[0];
  assign WAVE_OE_B = |com_w[1];
  assign CAPTURE_FLAG = cap_flag_q;
  assign COMPARE_FLAG_A = flag_w[0];
  assign COMPARE_FLAG_B = flag_w[1];
  assign OVERFLOW_FLAG = ovf_flag_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_force_a;
    wr_ctrl_a && PWDATA[`STC_A_FORCE_A] && !tick;
  endsequence
  sequence s_wr_then_tick;
    wr_cnt ##1 (tick && !wr_en);
  endsequence
  sequence s_lo_hi_read;
    (rd_setup && PADDR == `STC_OFS_CNT_LO) ##1 (PSEL && PENABLE) ##1 !PSEL ##1
      (rd_setup && PADDR == `STC_OFS_CNT_HI);
  endsequence

  property p_force_pwm;
    s_force_a ##0 !non_pwm |=> $stable(wave_w[0]);
  endproperty
  a_force_pwm: assert property (p_force_pwm) else $error("force acted in PWM mode");
  property p_force_toggle;
    s_force_a ##0 (non_pwm && PWDATA[7:6] == 2'b01) |=> wave_w[0] != $past(wave_w[0]);
  endproperty
  a_force_toggle: assert property (p_force_toggle) else $error("force did not toggle");
  property p_force_quiet;
    s_force_a ##0 (non_pwm && !flag_w[0] && !wr_cnt) |=> !flag_w[0] && $stable(cnt_q);
  endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("force set flag or count");
  property p_force_zero;
    rd_setup && PADDR == `STC_OFS_CTRL_A |=> PRDATA[3:2] == 2'b00;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force bits read nonzero");
  property p_normal_wrap;
    mode == 4'h0 && tick && cnt_q == `STC_MAX && !wr_cnt |=> cnt_q == 16'h0000 && ovf_flag_q;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");
  property p_pc_turn;
    cls == STC_PC && tick && !dir_down_q && at_top && !at_bot && !wr_cnt
      |=> dir_down_q && cnt_q == $past(cnt_q) - 16'h0001;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase correct turn wrong");
  property p_fast_buf;
    cls == STC_FAST && upd && !(wr_en && PADDR == `STC_OFS_CMPA_LO) |=> act_w[0] == $past(buf_w[0]);
  endproperty
  a_fast_buf: assert property (p_fast_buf) else $error("buffer not loaded at bottom");
  property p_capture;
    cap_hit |=> cap_q == $past(cnt_q) && cap_flag_q;
  endproperty
  a_capture: assert property (p_capture) else $error("capture not stored");
  property p_cap_off;
    icr_top && !(wr_en && PADDR == `STC_OFS_CAP_LO) |=> $stable(cap_q);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture ran while it sets top");
  property p_div8;
    cs == 3'h2 && tick |=> (!tick || cs != 3'h2) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");
  property p_atomic;
    wr_cnt |=> cnt_q == {$past(temp_q), $past(PWDATA[7:0])};
  endproperty
  a_atomic: assert property (p_atomic) else $error("counter write not atomic");
  property p_block;
    s_wr_then_tick ##0 (cnt_q == act_w[0] && !flag_w[0]) |=> !flag_w[0];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after write");
  property p_toggle;
    non_pwm && com_w[0] == 2'b01 && match_w[0] && !frc_w[0] |=> wave_w[0] != $past(wave_w[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match missing");
  property p_ack;
    CAP_VECTOR_ACK && !cap_set |=> !cap_flag_q;
  endproperty
  a_ack: assert property (p_ack) else $error("capture flag not cleared by ack");
  property p_hi_latch;
    s_lo_hi_read |=> PRDATA[7:0] == $past(cnt_q[15:8], 4);
  endproperty
  a_hi_latch: assert property (p_hi_latch) else $error("high byte not latched");
endmodule : stc_timer

// ### testbench/stc_pin_model.sv
// Pin-side model: drives capture and count pins, watches the waves
`timescale 1ns/1ps
module stc_pin_model (
  // Clock
  input wire logic clk,
  // Pins driven
  output logic cap_pin,
  output logic count_pin,
  // Pins watched
  input wire logic wave_a,
  input wire logic wave_b
);
  initial begin
    cap_pin = 1'b0;
    count_pin = 1'b0;
  end
  // Three cycles per level so no sample of the pin is missed
  task automatic pulses(input int n);
    repeat (n) begin
      count_pin <= 1'b1;
      repeat (3) @(posedge clk);
      count_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : pulses
  task automatic set_cap(input logic v, input int hold);
    cap_pin <= v;
    repeat (hold) @(posedge clk);
  endtask : set_cap
endmodule : stc_pin_model

// ### testbench/stc_timer_test.sv
// Self-checking bench for registers, counting, compare and capture
`timescale 1ns/1ps
`include "stc_defines.svh"
module stc_timer_test;
  import stc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slverr, ack;
  logic cap, cnt, wa, oea, wb, oeb, fcap, fa, fb, fov;
  stc_byte_t paddr;
  stc_data_t pwdata, prdata;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  stc_timer u_dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CAPTURE_INPUT_PIN(cap), .EXTERNAL_COUNT_PIN(cnt),
    .WAVE_OUT_A(wa), .WAVE_OE_A(oea), .WAVE_OUT_B(wb), .WAVE_OE_B(oeb),
    .CAP_VECTOR_ACK(ack), .CAPTURE_FLAG(fcap), .COMPARE_FLAG_A(fa),
    .COMPARE_FLAG_B(fb), .OVERFLOW_FLAG(fov));
  stc_pin_model u_pins (.clk(clk), .cap_pin(cap), .count_pin(cnt), .wave_a(wa),
    .wave_b(wb));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Run is about 400 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end
  task automatic chk(input stc_byte_t seen, input stc_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input stc_byte_t a, input stc_byte_t d,
                     output stc_byte_t r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata[7:0];
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input stc_byte_t a, input stc_byte_t d);
    stc_byte_t r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input stc_byte_t a, input stc_byte_t e);
    stc_byte_t r;
    apb(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask : rd
  // High byte first: it only fills the shared temp
  task automatic w16(input stc_byte_t a, input stc_word_t v);
    wr(a + 8'h04, v[15:8]);
    wr(a, v[7:0]);
  endtask : w16
  task automatic r16(input stc_byte_t a, input stc_word_t v);
    rd(a, v[7:0]);
    rd(a + 8'h04, v[15:8]);
  endtask : r16
  task automatic t_regs();
    rd(`STC_OFS_CTRL_A, `STC_RST_BYTE);
    rd(`STC_OFS_CTRL_B, `STC_RST_BYTE);
    r16(`STC_OFS_CNT_LO, `STC_RST_WORD);
    r16(`STC_OFS_CMPA_LO, `STC_RST_WORD);
    w16(`STC_OFS_CMPB_LO, 16'hA55A);
    w16(`STC_OFS_CMPA_LO, 16'h1234);
    r16(`STC_OFS_CMPB_LO, 16'hA55A);
    r16(`STC_OFS_CMPA_LO, 16'h1234);
    wr(`STC_OFS_CTRL_B, 8'h18);
    rd(`STC_OFS_CTRL_B, 8'h18);
    wr(`STC_OFS_CTRL_B, 8'h00);
    wr(8'h30, 8'hFF);
    chk({7'h00, slverr}, 8'h01);
    $display("register test done");
  endtask : t_regs
  task automatic t_force();
    wr(`STC_OFS_CTRL_A, 8'h40);
    chk({7'h00, oea}, 8'h01);
    wr(`STC_OFS_CTRL_A, 8'h48);
    chk({7'h00, wa}, 8'h01);
    chk({7'h00, fa}, 8'h00);
    rd(`STC_OFS_CTRL_A, 8'h40);
    wr(`STC_OFS_CTRL_A, 8'h88);
    chk({7'h00, wa}, 8'h00);
    wr(`STC_OFS_CTRL_A, 8'h34);
    chk({7'h00, wb}, 8'h01);
    chk({7'h00, oeb}, 8'h01);
    wr(`STC_OFS_CTRL_A, 8'hC1);
    wr(`STC_OFS_CTRL_A, 8'hC9);
    chk({7'h00, wa}, 8'h00);
    wr(`STC_OFS_CTRL_A, 8'h00);
    $display("force test done");
  endtask : t_force
  task automatic t_count();
    w16(`STC_OFS_CMPA_LO, 16'h0010);
    w16(`STC_OFS_CMPB_LO, 16'h0020);
    w16(`STC_OFS_CNT_LO, 16'h0000);
    wr(`STC_OFS_CTRL_B, 8'h01);
    repeat (40) @(posedge clk);
    wr(`STC_OFS_CTRL_B, 8'h00);
    rd(`STC_OFS_FLAGS, 8'h18);
    chk({7'h00, fb}, 8'h01);
    wr(`STC_OFS_FLAGS, 8'h18);
    w16(`STC_OFS_CNT_LO, 16'h0010);
    wr(`STC_OFS_CTRL_B, 8'h01);
    repeat (20) @(posedge clk);
    chk({7'h00, fa}, 8'h00);
    w16(`STC_OFS_CNT_LO, 16'hFFF8);
    repeat (30) @(posedge clk);
    wr(`STC_OFS_CTRL_B, 8'h00);
    chk({7'h00, fov}, 8'h01);
    wr(`STC_OFS_FLAGS, 8'h3C);
    w16(`STC_OFS_CNT_LO, 16'h0000);
    wr(`STC_OFS_CTRL_B, 8'h07);
    u_pins.pulses(3);
    wr(`STC_OFS_CTRL_B, 8'h06);
    u_pins.pulses(2);
    wr(`STC_OFS_CTRL_B, 8'h00);
    r16(`STC_OFS_CNT_LO, 16'h0005);
    $display("count test done");
  endtask : t_count
  task automatic t_capture();
    w16(`STC_OFS_CNT_LO, 16'h0055);
    wr(`STC_OFS_CTRL_B, 8'h40);
    u_pins.set_cap(1'b1, 20);
    chk({7'h00, fcap}, 8'h01);
    r16(`STC_OFS_CAP_LO, 16'h0055);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    chk({7'h00, fcap}, 8'h00);
    w16(`STC_OFS_CNT_LO, 16'h0066);
    wr(`STC_OFS_CTRL_B, 8'h80);
    u_pins.set_cap(1'b0, 2);
    u_pins.set_cap(1'b1, 20);
    chk({7'h00, fcap}, 8'h00);
    u_pins.set_cap(1'b0, 20);
    r16(`STC_OFS_CAP_LO, 16'h0066);
    wr(`STC_OFS_FLAGS, 8'h20);
    rd(`STC_OFS_FLAGS, 8'h00);
    wr(`STC_OFS_CTRL_B, 8'h58);
    u_pins.set_cap(1'b1, 20);
    chk({7'h00, fcap}, 8'h00);
    $display("capture test done");
  endtask : t_capture
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ack = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_force();
    t_count();
    t_capture();
    end_of_test();
  end
endmodule : stc_timer_test
